/* ebc_bus_cycle.sv */
/*
 * ebc_bus_cycle: drives the attribute and start signals of cycles this device
 * starts, watches alternate-master cycles to steer memory control and its own
 * acknowledge, and latches boot straps from the interrupt pins during reset.
 * Assumes region decode, DRAM timing and arbitration live outside; pins come in
 * already split into input, output and enable, all synchronous to i_clk.
 */
`timescale 1ns/1ns
module ebc_bus_cycle
#(
   parameter int WAIT_W = ebc_pkg::EBC_WAIT_W
)
(
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   // internal request for an own bus cycle
   input  wire logic              i_req,
   input  wire logic              i_req_read,
   input  wire logic [1:0]        i_req_width,
   input  wire logic [1:0]        i_req_kind,
   input  wire logic              i_req_code,
   input  wire logic              i_req_super,
   input  wire logic              i_req_ctrl_reg,
   input  wire logic              i_req_dram,
   input  wire logic              i_dram_done,
   output logic                   o_busy,
   output logic                   o_done,
   // bus ownership
   input  wire logic              i_alt_owner,
   // pins, split
   input  wire logic              i_rw,
   output logic                   o_rw,
   output logic                   o_rw_oe,
   input  wire logic [1:0]        i_transfer_width_code,
   output logic [1:0]             o_transfer_width_code,
   output logic                   o_transfer_width_code_oe,
   output logic [1:0]             o_access_kind_code,
   output logic                   o_access_kind_code_oe,
   output logic                   o_access_modifier_bit,
   output logic                   o_access_modifier_bit_oe,
   input  wire logic              i_transfer_start_strobe_n,
   output logic                   o_transfer_start_strobe_n,
   output logic                   o_transfer_start_strobe_oe,
   input  wire logic              i_cycle_done_ack_n,
   output logic                   o_cycle_done_ack_n,
   output logic                   o_cycle_done_ack_oe,
   // alternate-master region decode from chip-select and DRAM logic
   input  wire logic              i_alt_hit_region,
   input  wire logic              i_alt_hit_dram,
   input  wire logic              i_alt_master_auto_ack,
   input  wire logic [WAIT_W-1:0] i_alt_wait_states,
   output logic                   o_alt_sel_req,
   output logic                   o_alt_dram_req,
   output logic                   o_alt_read,
   output logic [1:0]             o_alt_width,
   // boot straps
   input  wire logic [2:0]        i_irq_n,
   output logic                   o_boot_auto_ack,
   output logic [WAIT_W-1:0]      o_boot_wait,
   output logic [1:0]             o_boot_port
);
   ebc_pkg::ebc_own_st_t own_q, own_d;
   logic       rw_q, rw_d, rw_oe_q, rw_oe_d;
   logic [1:0] wid_q, wid_d, kind_q, kind_d;
   logic       attr_oe_q, attr_oe_d;
   logic       mod_q, mod_d, mod_late_q, mod_late_d;
   logic       start_n_q, start_n_d, start_oe_q, start_oe_d;
   logic       dram_q, dram_d, done_q, done_d;
   logic       mod_early, mod_late;

   // modifier pair for a new request, start-clock value then later value
   always_comb
   begin
      mod_early = i_req_code;
      mod_late  = i_req_super;
      unique case (i_req_kind)
         ebc_pkg::EBC_KIND_NORMAL:
         begin
            mod_early = i_req_code;
            mod_late  = i_req_super;
         end
         ebc_pkg::EBC_KIND_DMA:
         begin
            mod_early = 1'b1;
            mod_late  = 1'b0;
         end
         ebc_pkg::EBC_KIND_EMUL:
         begin
            mod_early = i_req_code;
            mod_late  = 1'b1;
         end
         ebc_pkg::EBC_KIND_CPU:
         begin
            mod_early = !i_req_ctrl_reg;
            mod_late  = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      own_d      = own_q;
      rw_d       = rw_q;
      rw_oe_d    = rw_oe_q;
      wid_d      = wid_q;
      kind_d     = kind_q;
      attr_oe_d  = attr_oe_q;
      mod_d      = mod_q;
      mod_late_d = mod_late_q;
      start_n_d  = 1'b1;
      start_oe_d = start_oe_q;
      dram_d     = dram_q;
      done_d     = 1'b0;
      unique case (own_q)
         ebc_pkg::EBC_OWN_IDLE:
         begin
            rw_oe_d    = 1'b0;
            attr_oe_d  = 1'b0;
            start_oe_d = 1'b0;
            if (i_req && !i_alt_owner)
            begin
               own_d      = ebc_pkg::EBC_OWN_START;
               rw_d       = i_req_read;
               wid_d      = i_req_width;
               kind_d     = i_req_kind;
               mod_d      = mod_early;
               mod_late_d = mod_late;
               dram_d     = i_req_dram;
               rw_oe_d    = 1'b1;
               attr_oe_d  = 1'b1;
               start_oe_d = 1'b1;
               start_n_d  = 1'b0;
            end
         end
         ebc_pkg::EBC_OWN_START:
         begin
            // strobe drops after exactly one clock
            own_d = ebc_pkg::EBC_OWN_DATA;
            mod_d = mod_late_q;
         end
         ebc_pkg::EBC_OWN_DATA:
         begin
            // attributes untouched here until the cycle ends
            if (dram_q ? i_dram_done : !i_cycle_done_ack_n)
            begin
               // let go of the pins on the acknowledge edge so a new owner never overlaps
               own_d      = ebc_pkg::EBC_OWN_IDLE;
               done_d     = 1'b1;
               rw_oe_d    = 1'b0;
               attr_oe_d  = 1'b0;
               start_oe_d = 1'b0;
            end
         end
         default:
            own_d = ebc_pkg::EBC_OWN_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         own_q      <= ebc_pkg::EBC_OWN_IDLE;
         rw_q       <= 1'b1;
         rw_oe_q    <= 1'b0;
         wid_q      <= ebc_pkg::EBC_WID_LONG;
         kind_q     <= ebc_pkg::EBC_KIND_NORMAL;
         attr_oe_q  <= 1'b0;
         mod_q      <= 1'b0;
         mod_late_q <= 1'b0;
         start_n_q  <= 1'b1;
         start_oe_q <= 1'b0;
         dram_q     <= 1'b0;
         done_q     <= 1'b0;
      end
      else
      begin
         own_q      <= own_d;
         rw_q       <= rw_d;
         rw_oe_q    <= rw_oe_d;
         wid_q      <= wid_d;
         kind_q     <= kind_d;
         attr_oe_q  <= attr_oe_d;
         mod_q      <= mod_d;
         mod_late_q <= mod_late_d;
         start_n_q  <= start_n_d;
         start_oe_q <= start_oe_d;
         dram_q     <= dram_d;
         done_q     <= done_d;
      end
   end

   // alternate-master watcher; kind and modifier pins have no input path at all
   ebc_pkg::ebc_alt_st_t alt_q, alt_d;
   logic              sel_q, sel_d, adram_q, adram_d, aread_q, aread_d;
   logic [1:0]        awid_q, awid_d;
   logic              auto_q, auto_d;
   logic              ack_n_q, ack_n_d, ack_oe_q, ack_oe_d;
   logic              wait_load, wait_done;

   ebc_wait_cnt #(
      .W (WAIT_W)
   ) u_wait (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_load   (wait_load),
      .i_count  (i_alt_wait_states),
      .o_done   (wait_done)
   );

   always_comb
   begin
      alt_d     = alt_q;
      sel_d     = sel_q;
      adram_d   = adram_q;
      aread_d   = aread_q;
      awid_d    = awid_q;
      auto_d    = auto_q;
      ack_n_d   = 1'b1;
      ack_oe_d  = 1'b0;
      wait_load = 1'b0;
      unique case (alt_q)
         ebc_pkg::EBC_ALT_IDLE:
         begin
            if (i_alt_owner && !i_transfer_start_strobe_n)
            begin
               aread_d = i_rw;
               awid_d  = i_transfer_width_code;
               adram_d = i_alt_hit_dram;
               sel_d   = i_alt_hit_region && !i_alt_hit_dram;
               auto_d  = i_alt_master_auto_ack;
               if (i_alt_hit_dram || i_alt_hit_region)
               begin
                  alt_d     = ebc_pkg::EBC_ALT_WAIT;
                  wait_load = i_alt_hit_region && !i_alt_hit_dram
                              && i_alt_master_auto_ack;
               end
            end
         end
         ebc_pkg::EBC_ALT_WAIT:
         begin
            if (adram_q ? i_dram_done : (auto_q && wait_done))
            begin
               alt_d    = ebc_pkg::EBC_ALT_ACK;
               ack_n_d  = 1'b0;
               ack_oe_d = 1'b1;
            end
            else if (!adram_q && !auto_q && !i_cycle_done_ack_n)
            begin
               alt_d   = ebc_pkg::EBC_ALT_IDLE;
               sel_d   = 1'b0;
            end
         end
         ebc_pkg::EBC_ALT_ACK:
         begin
            alt_d   = ebc_pkg::EBC_ALT_IDLE;
            sel_d   = 1'b0;
            adram_d = 1'b0;
         end
         default:
            alt_d = ebc_pkg::EBC_ALT_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         alt_q    <= ebc_pkg::EBC_ALT_IDLE;
         sel_q    <= 1'b0;
         adram_q  <= 1'b0;
         aread_q  <= 1'b1;
         awid_q   <= ebc_pkg::EBC_WID_LONG;
         auto_q   <= 1'b0;
         ack_n_q  <= 1'b1;
         ack_oe_q <= 1'b0;
      end
      else
      begin
         alt_q    <= alt_d;
         sel_q    <= sel_d;
         adram_q  <= adram_d;
         aread_q  <= aread_d;
         awid_q   <= awid_d;
         auto_q   <= auto_d;
         ack_n_q  <= ack_n_d;
         ack_oe_q <= ack_oe_d;
      end
   end

   // straps caught on every clock while reset is held, frozen after release
   logic              baa_q, baa_d;
   logic [1:0]        bport_q, bport_d;

   always_comb
   begin
      baa_d   = baa_q;
      bport_d = bport_q;
      if (!i_resetn)
      begin
         baa_d = i_irq_n[ebc_pkg::EBC_STRAP_AA_BIT];
         unique case ({i_irq_n[ebc_pkg::EBC_STRAP_PS_HI], i_irq_n[ebc_pkg::EBC_STRAP_PS_LO]})
            ebc_pkg::EBC_PORT_32: bport_d = ebc_pkg::EBC_PORT_32;
            ebc_pkg::EBC_PORT_8:  bport_d = ebc_pkg::EBC_PORT_8;
            default:              bport_d = ebc_pkg::EBC_PORT_16;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      baa_q   <= baa_d;
      bport_q <= bport_d;
   end

   logic [WAIT_W-1:0] bwait_q;

   always_ff @(posedge i_clk)
   begin
      bwait_q <= baa_d ? WAIT_W'(ebc_pkg::EBC_BOOT_WAIT)
                       : WAIT_W'(ebc_pkg::EBC_WAIT_NONE);
   end

   assign o_busy                     = attr_oe_q;
   assign o_done                     = done_q;
   assign o_rw                       = rw_q;
   assign o_rw_oe                    = rw_oe_q;
   assign o_transfer_width_code      = wid_q;
   assign o_transfer_width_code_oe   = attr_oe_q;
   assign o_access_kind_code         = kind_q;
   assign o_access_kind_code_oe      = attr_oe_q;
   assign o_access_modifier_bit      = mod_q;
   assign o_access_modifier_bit_oe   = attr_oe_q;
   assign o_transfer_start_strobe_n  = start_n_q;
   assign o_transfer_start_strobe_oe = start_oe_q;
   assign o_cycle_done_ack_n         = ack_n_q;
   assign o_cycle_done_ack_oe        = ack_oe_q;
   assign o_alt_sel_req              = sel_q;
   assign o_alt_dram_req             = adram_q;
   assign o_alt_read                 = aread_q;
   assign o_alt_width                = awid_q;
   assign o_boot_auto_ack            = baa_q;
   assign o_boot_wait                = bwait_q;
   assign o_boot_port                = bport_q;
endmodule

/* ebc_pkg.sv */
/*
 * ebc_pkg: encodings and constants for the external bus cycle signalling block.
 * Assumes nothing beyond a SystemVerilog compiler; no imports are made from it.
 */
package ebc_pkg;
   // transfer width code
   localparam logic [1:0] EBC_WID_LONG = 2'h0;
   localparam logic [1:0] EBC_WID_BYTE = 2'h1;
   localparam logic [1:0] EBC_WID_WORD = 2'h2;
   localparam logic [1:0] EBC_WID_LINE = 2'h3;
   // access kind code
   localparam logic [1:0] EBC_KIND_NORMAL = 2'h0;
   localparam logic [1:0] EBC_KIND_DMA    = 2'h1;
   localparam logic [1:0] EBC_KIND_EMUL   = 2'h2;
   localparam logic [1:0] EBC_KIND_CPU    = 2'h3;
   // boot region port width
   localparam logic [1:0] EBC_PORT_32 = 2'h0;
   localparam logic [1:0] EBC_PORT_8  = 2'h1;
   localparam logic [1:0] EBC_PORT_16 = 2'h2;
   // strap pin positions on the interrupt pins
   localparam int EBC_STRAP_AA_BIT = 2;
   localparam int EBC_STRAP_PS_HI  = 1;
   localparam int EBC_STRAP_PS_LO  = 0;
   localparam int EBC_WAIT_W       = 4;
   localparam logic [3:0] EBC_BOOT_WAIT = 4'hf;
   localparam logic [3:0] EBC_WAIT_NONE = 4'h0;

   typedef enum logic [1:0]
   {
      EBC_OWN_IDLE  = 2'h0,
      EBC_OWN_START = 2'h1,
      EBC_OWN_DATA  = 2'h3
   } ebc_own_st_t;

   typedef enum logic [1:0]
   {
      EBC_ALT_IDLE = 2'h0,
      EBC_ALT_WAIT = 2'h1,
      EBC_ALT_ACK  = 2'h3
   } ebc_alt_st_t;
endpackage

/* ebc_wait_cnt.sv */
/*
 * ebc_wait_cnt: wait-state down counter used to time a self-generated acknowledge.
 * Assumes the loader pulses i_load once per cycle; o_done is a registered one-clock pulse.
 */
`timescale 1ns/1ns
module ebc_wait_cnt
#(
   parameter int W = 4
)
(
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_count,
   output logic              o_done
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         run_q;
   logic         run_d;
   logic         done_q;
   logic         done_d;

   always_comb
   begin
      cnt_d  = cnt_q;
      run_d  = run_q;
      done_d = 1'b0;
      if (i_load)
      begin
         cnt_d = i_count;
         run_d = 1'b1;
      end
      else if (run_q)
      begin
         if (cnt_q == '0)
         begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end
         else
            cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         run_q  <= run_d;
         done_q <= done_d;
      end
   end

   assign o_done = done_q;
endmodule

/* ebc_bus_cycle_assertions.sv */
/* ebc_bus_cycle_assertions: timing and encoding properties of ebc_bus_cycle.
   Assumes it is bound onto ebc_bus_cycle and sees only its ports. */
`timescale 1ns/1ns
module ebc_bus_cycle_assertions
#(
   parameter int WAIT_W = 4
)
(
   input wire logic              i_clk,
   input wire logic              i_resetn,
   input wire logic [1:0]        i_req_kind,
   input wire logic              i_req_code,
   input wire logic              i_req_super,
   input wire logic              i_dram_done,
   input wire logic              o_busy,
   input wire logic              o_done,
   input wire logic              o_rw,
   input wire logic [1:0]        o_transfer_width_code,
   input wire logic [1:0]        o_access_kind_code,
   input wire logic              o_access_modifier_bit,
   input wire logic              o_transfer_start_strobe_n,
   input wire logic              i_alt_owner,
   input wire logic              i_rw,
   input wire logic [1:0]        i_transfer_width_code,
   input wire logic              i_transfer_start_strobe_n,
   input wire logic              i_cycle_done_ack_n,
   input wire logic              o_cycle_done_ack_n,
   input wire logic              o_cycle_done_ack_oe,
   input wire logic              i_alt_hit_region,
   input wire logic              i_alt_hit_dram,
   input wire logic              i_alt_master_auto_ack,
   input wire logic [WAIT_W-1:0] i_alt_wait_states,
   input wire logic              o_alt_sel_req,
   input wire logic              o_alt_dram_req,
   input wire logic              o_alt_read,
   input wire logic [1:0]        o_alt_width,
   input wire logic [2:0]        i_irq_n,
   input wire logic              o_boot_auto_ack,
   input wire logic [WAIT_W-1:0] o_boot_wait,
   input wire logic [1:0]        o_boot_port
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_own_start;
      $fell(o_transfer_start_strobe_n);
   endsequence
   // idle alt side: no request and no own acknowledge pending
   sequence s_alt_start;
      i_alt_owner && !i_transfer_start_strobe_n && !o_alt_sel_req && !o_alt_dram_req
         && !o_cycle_done_ack_oe;
   endsequence
   property p_strobe_one;
      s_own_start |=> o_transfer_start_strobe_n;
   endproperty
   a_strobe_one: assert property (p_strobe_one) else $error("start strobe not one clock");
   property p_kind;
      s_own_start |-> o_access_kind_code == $past(i_req_kind);
   endproperty
   a_kind: assert property (p_kind) else $error("access kind mismatch");
   property p_mod_normal;
      s_own_start ##0 (o_access_kind_code == 2'h0) |-> (o_access_modifier_bit == $past(i_req_code))
         ##1 (o_access_modifier_bit == $past(i_req_super, 2));
   endproperty
   a_mod_normal: assert property (p_mod_normal) else $error("normal modifier wrong");
   property p_mod_dma;
      s_own_start ##0 (o_access_kind_code == 2'h1) |-> o_access_modifier_bit ##1 !o_access_modifier_bit;
   endproperty
   a_mod_dma: assert property (p_mod_dma) else $error("dma modifier wrong");
   property p_attr_hold;
      o_busy && $past(o_busy) |-> $stable({o_rw, o_transfer_width_code, o_access_kind_code});
   endproperty
   a_attr_hold: assert property (p_attr_hold) else $error("attributes moved in cycle");
   property p_done;
      $rose(o_done) |-> !o_busy && ($past(!i_cycle_done_ack_n) || $past(i_dram_done));
   endproperty
   a_done: assert property (p_done) else $error("done without completion");
   property p_alt_capture;
      s_alt_start ##0 (i_alt_hit_dram || i_alt_hit_region) |=> o_alt_read == $past(i_rw)
         && o_alt_width == $past(i_transfer_width_code) && o_alt_dram_req == $past(i_alt_hit_dram)
         && o_alt_sel_req == !$past(i_alt_hit_dram);
   endproperty
   a_alt_capture: assert property (p_alt_capture) else $error("alt cycle decode wrong");
   property p_alt_auto0;
      s_alt_start ##0 (i_alt_hit_region && !i_alt_hit_dram && i_alt_master_auto_ack
         && i_alt_wait_states == '0) |-> ##2 o_cycle_done_ack_n ##1 !o_cycle_done_ack_n;
   endproperty
   a_alt_auto0: assert property (p_alt_auto0) else $error("auto ack timing wrong");
   property p_alt_dram;
      o_alt_dram_req && i_dram_done |=> !o_cycle_done_ack_n && o_cycle_done_ack_oe;
   endproperty
   a_alt_dram: assert property (p_alt_dram) else $error("dram ack missing");
   property p_alt_noauto;
      o_alt_sel_req && !o_cycle_done_ack_oe && !i_cycle_done_ack_n |=> !o_alt_sel_req;
   endproperty
   a_alt_noauto: assert property (p_alt_noauto) else $error("select held after ack");
   property p_straps;
      $rose(i_resetn) |-> o_boot_auto_ack == $past(i_irq_n[2]) && o_boot_port ==
         ($past(i_irq_n[1:0]) == 2'h0 ? 2'h0 : ($past(i_irq_n[1:0]) == 2'h1 ? 2'h1 : 2'h2))
         ##1 o_boot_wait == (o_boot_auto_ack ? 4'hf : 4'h0);
   endproperty
   a_straps: assert property (p_straps) else $error("boot straps wrong");
endmodule

bind ebc_bus_cycle ebc_bus_cycle_assertions #(.WAIT_W(WAIT_W)) u_chk (.*);

/* ebc_slave_model.sv */
/* ebc_slave_model: external slave ending cycles with the synchronous acknowledge.
   Assumes a resolved start strobe; enable and delay come from the bench. */
`timescale 1ns/1ns
module ebc_slave_model
(
   input  wire logic       i_clk,
   input  wire logic       i_strobe_n,
   input  wire logic       i_en,
   input  wire logic [3:0] i_delay,
   output logic            o_ack_n
);
   logic [3:0] cnt_q;
   initial
   begin
      o_ack_n = 1'h1;
      cnt_q = 4'h0;
   end
   // one clock of ack; released line reads back high, the inverse of the low level
   always @(posedge i_clk)
   begin
      o_ack_n <= 1'h1;
      if (cnt_q != 4'h0)
      begin
         cnt_q <= cnt_q - 4'h1;
         o_ack_n <= (cnt_q != 4'h1);
      end
      else if (!i_strobe_n && i_en)
      begin
         o_ack_n <= (i_delay != 4'h0);
         cnt_q <= i_delay;
      end
   end
endmodule

/* ebc_bus_cycle_tb.sv */
/* ebc_bus_cycle_tb: self-checking bench for ebc_bus_cycle with a slave model.
   Assumes the checker binds itself; the bench plays the alternate master. */
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module ebc_bus_cycle_tb;
   logic       i_clk, i_resetn, i_req, i_req_read, i_req_code, i_req_super, i_req_ctrl_reg;
   logic       i_req_dram, i_dram_done, i_alt_owner, i_alt_hit_region, i_alt_hit_dram;
   logic       i_alt_master_auto_ack, m_ts_n, m_rw, s_en, s_ack_n, o_busy, o_done, o_rw;
   logic       o_rw_oe, o_transfer_width_code_oe, o_access_kind_code_oe, o_access_modifier_bit;
   logic       o_access_modifier_bit_oe, o_transfer_start_strobe_n, o_transfer_start_strobe_oe;
   logic       o_cycle_done_ack_n, o_cycle_done_ack_oe, o_alt_sel_req, o_alt_dram_req;
   logic       o_alt_read, o_boot_auto_ack;
   logic [1:0] i_req_width, i_req_kind, m_wid, o_transfer_width_code, o_access_kind_code;
   logic [1:0] o_alt_width, o_boot_port;
   logic [3:0] i_alt_wait_states, s_dly, o_boot_wait;
   logic [2:0] i_irq_n;
   int         err_total, total_checks;
   wire        i_rw = o_rw_oe ? o_rw : m_rw;
   wire  [1:0] i_transfer_width_code = o_transfer_width_code_oe ? o_transfer_width_code : m_wid;
   wire        i_transfer_start_strobe_n = o_transfer_start_strobe_oe ? o_transfer_start_strobe_n
                                           : m_ts_n;
   wire        i_cycle_done_ack_n = o_cycle_done_ack_oe ? o_cycle_done_ack_n : s_ack_n;
   // kind, code, super, ctrl reg, modifier at start, modifier after
   localparam logic [6:0] ROWS [8] = '{7'h1b, 7'h00, 7'h09, 7'h12, 7'h22, 7'h49, 7'h6a, 7'h6c};
   // hits and auto and rw, width, waits, ack cycle count, own ack, slave on
   localparam logic [16:0] ALTS [7] = '{{4'h5, 2'h1, 4'h0, 5'h02, 2'h2},
      {4'ha, 2'h2, 4'h0, 5'h03, 2'h2}, {4'hb, 2'h3, 4'h3, 5'h06, 2'h2},
      {4'ha, 2'h0, 4'hf, 5'h12, 2'h2}, {4'h9, 2'h1, 4'h5, 5'h01, 2'h1},
      {4'he, 2'h2, 4'h2, 5'h02, 2'h2}, {4'h3, 2'h0, 4'h0, 5'h14, 2'h0}};

   ebc_bus_cycle dut (.*);
   ebc_slave_model slv (.i_clk(i_clk), .i_strobe_n(i_transfer_start_strobe_n), .i_en(s_en),
                        .i_delay(s_dly), .o_ack_n(s_ack_n));

   initial
   begin
      i_clk = 1'h0;
      forever #2 i_clk = ~i_clk;
   end

   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic own(input logic [6:0] r, input logic [1:0] w, input logic dram);
      int n;
      @(posedge i_clk);
      s_en <= 1'h1;
      i_req <= 1'h1;
      i_req_dram <= dram;
      i_req_read <= w[0];
      i_req_width <= w;
      {i_req_kind, i_req_code, i_req_super, i_req_ctrl_reg} <= r[6:2];
      for (n = 0; n < 8 && o_transfer_start_strobe_n !== 1'h0; n++)
      begin
         @(posedge i_clk);
         #1;
      end
      `CHK(o_transfer_start_strobe_n, 1'h0)
      `CHK({o_rw_oe, o_transfer_width_code_oe, o_rw, o_transfer_width_code}, {2'h3, w[0], w})
      `CHK({o_access_kind_code_oe, o_access_kind_code}, {1'h1, r[6:5]})
      `CHK({o_access_modifier_bit_oe, o_access_modifier_bit}, {1'h1, r[1]})
      i_req <= 1'h0;
      @(posedge i_clk);
      #1;
      `CHK({o_transfer_start_strobe_n, o_access_modifier_bit}, {1'h1, r[0]})
      `CHK({o_rw, o_transfer_width_code, o_access_kind_code}, {w[0], w, r[6:5]})
      if (dram)
      begin
         repeat (3) @(posedge i_clk);
         #1;
         `CHK(o_busy, 1'h1)
         i_dram_done <= 1'h1;
         @(posedge i_clk);
         i_dram_done <= 1'h0;
         #1;
      end
      for (n = 0; n < 9 && o_done !== 1'h1; n++)
      begin
         @(posedge i_clk);
         #1;
      end
      `CHK({o_done, o_busy, o_rw_oe, o_access_kind_code_oe}, 4'h8)
   endtask

   task automatic alt(input logic [16:0] a);
      int k;
      @(posedge i_clk);
      {i_alt_hit_region, i_alt_hit_dram, i_alt_master_auto_ack} <= a[16:14];
      {m_rw, m_wid, i_alt_wait_states} <= a[13:7];
      s_en <= a[0];
      i_alt_owner <= 1'h1;
      m_ts_n <= 1'h0;
      @(posedge i_clk);
      m_ts_n <= 1'h1;
      #1;
      `CHK({o_alt_sel_req, o_alt_dram_req}, {a[16] & ~a[15], a[15]})
      if (a[16] | a[15])
         `CHK({o_alt_read, o_alt_width}, a[13:11])
      `CHK({o_rw_oe, o_transfer_width_code_oe, o_access_kind_code_oe, o_access_modifier_bit_oe}, 4'h0)
      i_dram_done <= a[15];
      for (k = 1; k < 20 && i_cycle_done_ack_n !== 1'h0; k++)
      begin
         @(posedge i_clk);
         i_dram_done <= 1'h0;
         #1;
      end
      `CHK(k, int'(a[6:2]))
      `CHK(o_cycle_done_ack_oe, a[1])
      i_alt_owner <= 1'h0;
      m_rw <= ~m_rw;
      repeat (2) @(posedge i_clk);
      #1;
      `CHK({o_alt_sel_req, o_alt_dram_req, o_cycle_done_ack_oe}, 3'h0)
   endtask

   initial
   begin
      #40000;
      err_total++;
      wrap_up();
   end

   initial
   begin
      {i_resetn, i_req, i_req_read, i_req_code, i_req_super, i_req_ctrl_reg} = '0;
      {i_req_dram, i_dram_done, i_alt_owner, i_alt_hit_region, i_alt_hit_dram} = '0;
      {i_alt_master_auto_ack, i_req_width, i_req_kind, i_alt_wait_states, m_rw, m_wid} = '0;
      {m_ts_n, s_en, s_dly, i_irq_n} = {2'h3, 4'h0, 3'h4};
      err_total = 0;
      total_checks = 0;
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'h1;
      for (int i = 0; i < 8; i++)
      begin
         s_dly <= 4'(i % 3);
         own(ROWS[i], 2'(i), 1'h0);
      end
      // slave answers on the clock after the strobe, as the alt rows expect
      s_dly <= 4'h0;
      for (int i = 0; i < 7; i++)
         alt(ALTS[i]);
      own(ROWS[3], 2'h2, 1'h1);
      // strap sweep doubles as reset in mid-run
      for (int s = 0; s < 8; s++)
      begin
         @(posedge i_clk);
         i_resetn <= 1'h0;
         i_irq_n <= s[2:0];
         repeat (2) @(posedge i_clk);
         #1;
         `CHK({o_transfer_start_strobe_n, o_transfer_start_strobe_oe, o_busy}, 3'h4)
         i_resetn <= 1'h1;
         @(posedge i_clk);
         #1;
         `CHK({o_boot_auto_ack, o_boot_wait}, {s[2], s[2] ? 4'hf : 4'h0})
         `CHK(o_boot_port, s[1:0] == 2'h0 ? 2'h0 : (s[1:0] == 2'h1 ? 2'h1 : 2'h2))
      end
      wrap_up();
   end
endmodule
